// >>> rtl/drc_dma_ctrl.sv
// two-channel dma request, arbitration and transfer-cycle control with an apb register file
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "drc_defines.svh"

// How it works
// - any address parity; cycles = reads*j + writes*k
// - byte units take one read, one write
// - word units: two each if odd or 8-bit bus
// - coefficient 1, 2 or 3 by memory area
// - writing enable 1 activates the channel
// - first transfer reloads forward pointer from chosen pointer
// - first transfer reloads counter from reload register
// - rewriting enable 1 restarts channel from initial state
// - one preselected request source per channel
// - request flag sets regardless of enable
// - request flag clears just before transfer starts
// - software writes 0 clear flag, 1 ignored
// - peripheral requests set flag with their interrupt pulse
// - external pin edge, as selected, sets flag
// - same-cycle requests set all flags together
// - channel zero first, then bus back to processor
// - channel one after one processor access, then handback
// - dma uses pin-chosen width for all areas, only in expansion mode
module drc_dma_ctrl
	import drc_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic [3:0]  periph_irq_in,
	input  wire logic [1:0]  external_interrupt_input_in,
	input  wire logic        byte_bus_pin_in,
	input  wire logic        expansion_mode_in,
	input  wire logic        cpu_access_done_in,
	output logic             dma_bus_own_out,
	output logic             dma_channel_out,
	output logic      [19:0] dma_addr_out,
	output logic      [3:0]  dma_unit_cycles_out,
	output logic             dma_unit_done_out
);
	logic [1:0]  rst_sync;
	logic        rst_n;
	logic [2:0]  ext_sync [2];
	logic [1:0]  ext_stb;
	logic [1:0]  ext_prev;
	logic [2:0]  byte_sync;
	logic        byte_stb;
	logic [1:0]  next_ext_stb;
	logic        next_byte_stb;

	logic [11:0] ctrl [2];
	logic [1:0]  req_flag;
	logic [1:0]  reload_pend;
	logic [19:0] src_ptr [2];
	logic [19:0] dst_ptr [2];
	logic [19:0] fwd_ptr [2];
	logic [15:0] reload [2];
	logic [15:0] count [2];
	drc_state_t  state;
	logic        cur_ch;
	logic [3:0]  cyc_left;
	logic [31:0] prdata;
	logic        pslverr;
	logic        unit_done;

	logic [11:0] next_ctrl [2];
	logic [1:0]  next_req_flag;
	logic [1:0]  next_reload_pend;
	logic [19:0] next_src_ptr [2];
	logic [19:0] next_dst_ptr [2];
	logic [19:0] next_fwd_ptr [2];
	logic [15:0] next_reload [2];
	logic [15:0] next_count [2];
	drc_state_t  next_state;
	logic        next_cur_ch;
	logic [3:0]  next_cyc_left;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        next_unit_done;

	// bus cycles for one side of a unit
	function automatic logic [1:0] drc_bus_cycles(input logic unit_byte, input logic odd,
		input logic bus8);
		if (unit_byte)
			return `DRC_BUS_CYC_ONE;
		return (odd || bus8) ? `DRC_BUS_CYC_TWO : `DRC_BUS_CYC_ONE;
	endfunction : drc_bus_cycles

	// cycle coefficient of one memory area
	function automatic logic [1:0] drc_coef(input logic [2:0] area_bits);
		case (drc_area_t'(area_bits))
			AREA_INT_NOWAIT, AREA_EXT_SEP_NOWAIT: return `DRC_COEF_ONE;
			AREA_INT_WAIT, AREA_SPECIAL_REG, AREA_EXT_SEP_WAIT: return `DRC_COEF_TWO;
			AREA_EXT_MUX: return `DRC_COEF_THREE;
			default: return `DRC_COEF_THREE; // unused codes treated as slowest
		endcase
	endfunction : drc_coef

	// reset release through two flip-flops
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// pin inputs: a change counts once the second and third stages agree
	always_comb begin
		next_byte_stb = (byte_sync[1] == byte_sync[2]) ? byte_sync[2] : byte_stb;
		for (int c = 0; c < 2; c++)
			next_ext_stb[c] = (ext_sync[c][1] == ext_sync[c][2]) ? ext_sync[c][2] : ext_stb[c];
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			byte_sync <= 3'h0;
			byte_stb  <= 1'b0;
			ext_sync  <= '{3'h0, 3'h0};
			ext_stb   <= 2'h0;
			ext_prev  <= 2'h0;
		end else begin
			byte_sync <= {byte_sync[1:0], byte_bus_pin_in};
			byte_stb  <= next_byte_stb;
			for (int c = 0; c < 2; c++)
				ext_sync[c] <= {ext_sync[c][1:0], external_interrupt_input_in[c]};
			ext_stb   <= next_ext_stb;
			ext_prev  <= ext_stb;
		end
	end

	// registers, request flags, arbitration and cycle counting
	always_comb begin
		logic        wr;
		logic        rd_setup;
		logic        ch;
		logic        mapped;
		logic [4:0]  off;
		logic [1:0]  ev;
		logic        bus8;
		logic        s;
		logic        start;
		logic [19:0] a_src;
		logic [19:0] a_dst;
		logic [19:0] base;
		logic [1:0]  rd_cyc;
		logic [1:0]  wr_cyc;
		logic [3:0]  total;
		next_ctrl        = ctrl;
		next_req_flag    = req_flag;
		next_reload_pend = reload_pend;
		next_src_ptr     = src_ptr;
		next_dst_ptr     = dst_ptr;
		next_fwd_ptr     = fwd_ptr;
		next_reload      = reload;
		next_count       = count;
		next_state       = state;
		next_cur_ch      = cur_ch;
		next_cyc_left    = cyc_left;
		next_prdata      = prdata;
		next_pslverr     = pslverr;
		next_unit_done   = 1'b0;
		ch       = paddr_in[`DRC_CH_SEL_BIT];
		off      = paddr_in[4:0];
		mapped   = (paddr_in == `DRC_ADDR_SWREQ) ||
			((paddr_in[7:6] == 2'h0) && (off[1:0] == 2'h0) && (off <= `DRC_OFF_FWD));
		wr       = psel_in && penable_in && pwrite_in && mapped;
		rd_setup = psel_in && !penable_in;
		bus8     = byte_stb && expansion_mode_in; // 8-bit bus only outside single-chip
		s        = 1'b0;
		start    = 1'b0;
		a_src    = `DRC_PTR_RESET;
		a_dst    = `DRC_PTR_RESET;
		base     = `DRC_PTR_RESET;
		rd_cyc   = `DRC_BUS_CYC_ONE;
		wr_cyc   = `DRC_BUS_CYC_ONE;
		total    = 4'h0;
		ev       = 2'h0;
		// request event per channel from its one selected source
		for (int c = 0; c < 2; c++) begin
			case (drc_src_t'(ctrl[c][`DRC_CTRL_REQ_SRC]))
				SRC_PERIPH0: ev[c] = periph_irq_in[0];
				SRC_PERIPH1: ev[c] = periph_irq_in[1];
				SRC_PERIPH2: ev[c] = periph_irq_in[2];
				SRC_PERIPH3: ev[c] = periph_irq_in[3];
				SRC_SOFT: ev[c] = wr && (paddr_in == `DRC_ADDR_SWREQ) && pwdata_in[c];
				SRC_EXT_RISE: ev[c] = ext_stb[c] && !ext_prev[c];
				SRC_EXT_FALL: ev[c] = !ext_stb[c] && ext_prev[c];
				default: ev[c] = 1'b0;
			endcase
		end

		// read data and error are caught in the setup cycle so both leave flip-flops
		if (rd_setup) begin
			next_pslverr = !mapped;
			case (off)
				`DRC_OFF_CTRL: next_prdata = {20'h00000, ctrl[ch]};
				`DRC_OFF_REQ: next_prdata = {31'h00000000, req_flag[ch]};
				`DRC_OFF_SRC: next_prdata = {12'h000, src_ptr[ch]};
				`DRC_OFF_DST: next_prdata = {12'h000, dst_ptr[ch]};
				`DRC_OFF_RELOAD: next_prdata = {16'h0000, reload[ch]};
				`DRC_OFF_COUNT: next_prdata = {16'h0000, count[ch]};
				`DRC_OFF_FWD: next_prdata = {12'h000, fwd_ptr[ch]};
				default: next_prdata = 32'h00000000;
			endcase
			if (!mapped || paddr_in == `DRC_ADDR_SWREQ)
				next_prdata = 32'h00000000;
		end

		// arbitration and cycle count of one transfer unit
		case (state)
			ST_IDLE: begin
				// channel zero wins when both are pending; a disabled flag only waits
				if (ctrl[0][`DRC_CTRL_ENABLE] && req_flag[0]) begin
					start = 1'b1;
					s     = 1'b0;
				end else if (ctrl[1][`DRC_CTRL_ENABLE] && req_flag[1]) begin
					start = 1'b1;
					s     = 1'b1;
				end
				if (start) begin
					base = ctrl[s][`DRC_CTRL_FWD_DST] ? dst_ptr[s] : src_ptr[s];
					if (reload_pend[s]) begin
						next_fwd_ptr[s]     = base;
						next_count[s]       = reload[s];
						next_reload_pend[s] = 1'b0;
					end
					a_src  = (!ctrl[s][`DRC_CTRL_FWD_DST]) ? next_fwd_ptr[s] : src_ptr[s];
					a_dst  = ctrl[s][`DRC_CTRL_FWD_DST] ? next_fwd_ptr[s] : dst_ptr[s];
					rd_cyc = drc_bus_cycles(ctrl[s][`DRC_CTRL_UNIT_BYTE], a_src[0], bus8);
					wr_cyc = drc_bus_cycles(ctrl[s][`DRC_CTRL_UNIT_BYTE], a_dst[0], bus8);
					total  = {2'h0, rd_cyc} * {2'h0, drc_coef(ctrl[s][`DRC_CTRL_SRC_AREA])}
						+ {2'h0, wr_cyc} * {2'h0, drc_coef(ctrl[s][`DRC_CTRL_DST_AREA])};
					next_req_flag[s] = 1'b0;
					next_cur_ch      = s;
					next_cyc_left    = total - 4'h1;
					next_state       = ST_XFER;
				end
			end
			ST_XFER: begin
				if (cyc_left == 4'h0) begin
					next_fwd_ptr[cur_ch] = fwd_ptr[cur_ch]
						+ (ctrl[cur_ch][`DRC_CTRL_UNIT_BYTE] ? 20'h00001 : 20'h00002);
					next_count[cur_ch]   = count[cur_ch] - 16'h0001;
					if (count[cur_ch] == 16'h0001)
						next_ctrl[cur_ch][`DRC_CTRL_ENABLE] = 1'b0; // last unit ends activity
					next_unit_done = 1'b1;
					next_state     = ST_CPU; // bus back to the processor
				end else begin
					next_cyc_left = cyc_left - 4'h1;
				end
			end
			ST_CPU: begin
				// the next unit waits for one processor access
				if (cpu_access_done_in)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase

		// software writes land after hardware updates so a restart is never lost
		if (wr && paddr_in != `DRC_ADDR_SWREQ) begin
			case (off)
				`DRC_OFF_CTRL: begin
					next_ctrl[ch] = pwdata_in[11:0];
					if (pwdata_in[`DRC_CTRL_ENABLE])
						next_reload_pend[ch] = 1'b1;
				end
				`DRC_OFF_REQ: begin
					if (!pwdata_in[0])
						next_req_flag[ch] = 1'b0;
				end
				`DRC_OFF_SRC: next_src_ptr[ch] = pwdata_in[19:0];
				`DRC_OFF_DST: next_dst_ptr[ch] = pwdata_in[19:0];
				`DRC_OFF_RELOAD: next_reload[ch] = pwdata_in[15:0];
				default: ; // count and pointer are read-only
			endcase
		end

		// a request in the clearing cycle still sets the flag; both channels at once
		next_req_flag = next_req_flag | ev;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl        <= '{`DRC_CTRL_RESET, `DRC_CTRL_RESET};
			req_flag    <= 2'h0;
			reload_pend <= 2'h0;
			src_ptr     <= '{`DRC_PTR_RESET, `DRC_PTR_RESET};
			dst_ptr     <= '{`DRC_PTR_RESET, `DRC_PTR_RESET};
			fwd_ptr     <= '{`DRC_PTR_RESET, `DRC_PTR_RESET};
			reload      <= '{`DRC_CNT_RESET, `DRC_CNT_RESET};
			count       <= '{`DRC_CNT_RESET, `DRC_CNT_RESET};
			state       <= ST_IDLE;
			cur_ch      <= 1'b0;
			cyc_left    <= 4'h0;
			prdata      <= 32'h00000000;
			pslverr     <= 1'b0;
			unit_done   <= 1'b0;
		end else begin
			ctrl        <= next_ctrl;
			req_flag    <= next_req_flag;
			reload_pend <= next_reload_pend;
			src_ptr     <= next_src_ptr;
			dst_ptr     <= next_dst_ptr;
			fwd_ptr     <= next_fwd_ptr;
			reload      <= next_reload;
			count       <= next_count;
			state       <= next_state;
			cur_ch      <= next_cur_ch;
			cyc_left    <= next_cyc_left;
			prdata      <= next_prdata;
			pslverr     <= next_pslverr;
			unit_done   <= next_unit_done;
		end
	end

	// zero-wait slave: every access phase completes at once
	assign pready_out          = psel_in && penable_in;
	assign pslverr_out         = psel_in && penable_in && pslverr;
	assign prdata_out          = prdata;
	assign dma_bus_own_out     = (state == ST_XFER);
	assign dma_channel_out     = cur_ch;
	assign dma_addr_out        = fwd_ptr[cur_ch];
	assign dma_unit_cycles_out = cyc_left;
	assign dma_unit_done_out   = unit_done;
endmodule : drc_dma_ctrl
`default_nettype wire

// >>> rtl/drc_defines.svh
// register offsets, field positions, reset values and counts of the dma request and cycle block
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH

`define DRC_CH_SEL_BIT      5
`define DRC_OFF_CTRL        5'h00
`define DRC_OFF_REQ         5'h04
`define DRC_OFF_SRC         5'h08
`define DRC_OFF_DST         5'h0c
`define DRC_OFF_RELOAD      5'h10
`define DRC_OFF_COUNT       5'h14
`define DRC_OFF_FWD         5'h18
`define DRC_ADDR_SWREQ      8'h40

`define DRC_CTRL_ENABLE     0
`define DRC_CTRL_UNIT_BYTE  1
`define DRC_CTRL_FWD_DST    2
`define DRC_CTRL_SRC_AREA   5:3
`define DRC_CTRL_DST_AREA   8:6
`define DRC_CTRL_REQ_SRC    11:9
`define DRC_CTRL_RESET      12'he00

`define DRC_ADDR_W          20
`define DRC_CNT_W           16
`define DRC_CNT_RESET       16'h0000
`define DRC_PTR_RESET       20'h00000
`define DRC_BUS_CYC_ONE     2'h1
`define DRC_BUS_CYC_TWO     2'h2
`define DRC_COEF_ONE        2'h1
`define DRC_COEF_TWO        2'h2
`define DRC_COEF_THREE      2'h3

`endif

// >>> rtl/drc_pkg.sv
// types of the dma request and cycle block
`include "drc_defines.svh"
package drc_pkg;
	// memory area kinds that set the cycle coefficient of one side
	typedef enum logic [2:0] {
		AREA_INT_NOWAIT,
		AREA_INT_WAIT,
		AREA_SPECIAL_REG,
		AREA_EXT_SEP_NOWAIT,
		AREA_EXT_SEP_WAIT,
		AREA_EXT_MUX
	} drc_area_t;
	// request source selection of one channel
	typedef enum logic [2:0] {
		SRC_PERIPH0,
		SRC_PERIPH1,
		SRC_PERIPH2,
		SRC_PERIPH3,
		SRC_SOFT,
		SRC_EXT_RISE,
		SRC_EXT_FALL,
		SRC_NONE
	} drc_src_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_XFER,
		ST_CPU
	} drc_state_t;
endpackage : drc_pkg

// >>> verif/drc_dma_ctrl_sva.sv
// assertion checker for the dma request and cycle control block
`timescale 1ns/1ps
`default_nettype none
module drc_dma_ctrl_sva (
	input wire logic        ref_clk_in,
	input wire logic        arst_n_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pready_out,
	input wire logic        cpu_access_done_in,
	input wire logic        dma_bus_own_out,
	input wire logic        dma_channel_out,
	input wire logic [19:0] dma_addr_out,
	input wire logic [3:0]  dma_unit_cycles_out,
	input wire logic        dma_unit_done_out
);
	logic pend;
	logic next_pend;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	// a finished unit owes the processor one access before the bus is taken again
	always_comb next_pend = dma_unit_done_out | (pend & ~cpu_access_done_in);
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pend <= 1'b0;
		end else begin
			pend <= next_pend;
		end
	end
	sequence s_last; dma_bus_own_out && dma_unit_cycles_out == 4'h0; endsequence
	sequence s_end; !dma_bus_own_out && dma_unit_done_out; endsequence
	property p_count; dma_bus_own_out && dma_unit_cycles_out != 4'h0 |=>
		dma_bus_own_out && dma_unit_cycles_out == $past(dma_unit_cycles_out) - 4'h1; endproperty
	property p_end; s_last |=> s_end; endproperty
	property p_pulse; dma_unit_done_out |-> $past(dma_bus_own_out) ##1 !dma_unit_done_out;
	endproperty
	// longest unit is two sides of two cycles times three
	property p_len; $rose(dma_bus_own_out) |-> dma_unit_cycles_out inside {[4'h1:4'hb]};
	endproperty
	property p_back; pend |-> !dma_bus_own_out; endproperty
	property p_step; dma_unit_done_out |->
		20'(dma_addr_out - $past(dma_addr_out)) inside {20'h1, 20'h2}; endproperty
	property p_chan; dma_bus_own_out && $past(dma_bus_own_out) |-> $stable(dma_channel_out);
	endproperty
	property p_ready; psel_in && penable_in |-> pready_out; endproperty
	a_count: assert property (p_count) else $error("unit cycle count slipped");
	a_end: assert property (p_end) else $error("unit did not end on last cycle");
	a_pulse: assert property (p_pulse) else $error("done pulse malformed");
	a_len: assert property (p_len) else $error("unit length out of range");
	a_back: assert property (p_back) else $error("bus taken before processor access");
	a_step: assert property (p_step) else $error("pointer step wrong");
	a_chan: assert property (p_chan) else $error("channel changed in a unit");
	a_ready: assert property (p_ready) else $error("access phase not answered");
endmodule : drc_dma_ctrl_sva
bind drc_dma_ctrl drc_dma_ctrl_sva chk (.ref_clk_in, .arst_n_in, .psel_in, .penable_in,
	.pready_out, .cpu_access_done_in, .dma_bus_own_out, .dma_channel_out, .dma_addr_out,
	.dma_unit_cycles_out, .dma_unit_done_out);
`default_nettype wire

// >>> verif/drc_cpu_model.sv
// processor model: makes one bus access after each dma unit, promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module drc_cpu_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic done_in,
	input wire logic slow_in,
	output logic     cpu_done_out
);
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	// one access per handback, slow mode stretches it to test the wait
	always_comb begin
		next_cnt = (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
		if (done_in) begin
			next_cnt = slow_in ? 3'h6 : 3'h1;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 3'h0;
		end else begin
			cnt <= next_cnt;
		end
	end
	assign cpu_done_out = (cnt == 3'h1);
endmodule : drc_cpu_model
`default_nettype wire

// >>> verif/dma_request_and_cycle_control_bench.sv
// self-checking bench of the dma request and cycle control block
`timescale 1ns/1ps
`default_nettype none
module dma_request_and_cycle_control_bench;
	logic ref_clk_in = 1'b0, arst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
	logic pwrite_in = 1'b0, byte_bus_pin_in = 1'b0, expansion_mode_in = 1'b0, slow = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, rd, lf = 32'h0001083b;
	logic [3:0] periph_irq_in = 4'h0;
	logic [1:0] external_interrupt_input_in = 2'h0;
	logic err;
	wire logic [31:0] prdata_out;
	wire logic pready_out, pslverr_out, cpu_access_done_in, dma_bus_own_out;
	wire logic dma_channel_out, dma_unit_done_out;
	wire logic [19:0] dma_addr_out;
	wire logic [3:0] dma_unit_cycles_out;
	int n_errors = 0, checks = 0, cyc = 0, sa, da;
	drc_dma_ctrl dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .periph_irq_in(periph_irq_in),
		.external_interrupt_input_in(external_interrupt_input_in),
		.byte_bus_pin_in(byte_bus_pin_in), .expansion_mode_in(expansion_mode_in),
		.cpu_access_done_in(cpu_access_done_in), .dma_bus_own_out(dma_bus_own_out),
		.dma_channel_out(dma_channel_out), .dma_addr_out(dma_addr_out),
		.dma_unit_cycles_out(dma_unit_cycles_out), .dma_unit_done_out(dma_unit_done_out));
	drc_cpu_model cpu (.clk_in(ref_clk_in), .rst_n_in(arst_n_in), .done_in(dma_unit_done_out),
		.slow_in(slow), .cpu_done_out(cpu_access_done_in));
	always #25 ref_clk_in = ~ref_clk_in;
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : step
	function automatic int ncyc(input logic byt, input logic odd, input logic b8, input int ar);
		return ((byt || (!odd && !b8)) ? 1 : 2) * ((ar == 0 || ar == 3) ? 1 : (ar == 5) ? 3 : 2);
	endfunction : ncyc
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do @(posedge ref_clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	// waits for a unit, then counts its bus cycles
	task automatic xfer(input logic ch, input int n);
		int k;
		k = 0;
		// look 1 ns after each edge so the state register has always settled
		#1;
		while (dma_bus_own_out !== 1'b1) begin
			@(posedge ref_clk_in);
			#1;
		end
		cmp(dma_channel_out, ch);
		while (dma_bus_own_out === 1'b1) begin
			k++;
			@(posedge ref_clk_in);
			#1;
		end
		cmp(k, n);
	endtask : xfer
	task automatic close_out;
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	// a hang counts as a mismatch
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		apb(0, 8'h00, 0); cmp(rd, 32'he00);
		apb(0, 8'h3c, 0); cmp(err, 1);
		for (int i = 0; i < 16; i++) begin
			lf = step(lf);
			slow <= lf[11];
			expansion_mode_in <= lf[10];
			byte_bus_pin_in <= lf[9];
			sa = lf[2:0] % 6;
			da = lf[5:3] % 6;
			apb(1, 8'h08, {12'h0, lf[31:13], lf[7]});
			apb(1, 8'h0c, {12'h0, lf[27:9], lf[8]});
			apb(1, 8'h10, 1);
			apb(1, 8'h00, {20'h0, 3'h4, da[2:0], sa[2:0], 1'b0, lf[6], 1'b1});
			apb(1, 8'h40, 1);
			xfer(0, ncyc(lf[6], lf[7], lf[9] & lf[10], sa) + ncyc(lf[6], lf[8], lf[9] & lf[10], da));
			apb(0, 8'h18, 0); cmp(rd, ({12'h0, lf[31:13], lf[7]} + (lf[6] ? 1 : 2)) & 32'hfffff);
			apb(0, 8'h00, 0); cmp(rd[0], 0);
		end
		byte_bus_pin_in <= 1'b0;
		apb(1, 8'h08, 32'h100);
		apb(1, 8'h0c, 32'h200);
		apb(1, 8'h00, 32'h800);
		apb(1, 8'h04, 0);
		apb(1, 8'h40, 1);
		apb(0, 8'h04, 0); cmp(rd, 1);
		apb(1, 8'h04, 1);
		apb(0, 8'h04, 0); cmp(rd, 1);
		apb(1, 8'h04, 0);
		apb(0, 8'h04, 0); cmp(rd, 0);
		apb(1, 8'h40, 1);
		apb(1, 8'h10, 3);
		apb(1, 8'h00, 32'h801);
		xfer(0, 2);
		apb(0, 8'h04, 0); cmp(rd, 0);
		apb(0, 8'h14, 0); cmp(rd, 2);
		apb(1, 8'h00, 32'h801);
		apb(1, 8'h40, 1);
		xfer(0, 2);
		apb(0, 8'h14, 0); cmp(rd, 2);
		apb(0, 8'h18, 0); cmp(rd, 32'h102);
		for (int n = 0; n < 4; n++) begin
			apb(1, 8'h10, 1);
			apb(1, 8'h00, {20'h0, n[2:0], 9'h001});
			@(posedge ref_clk_in) periph_irq_in <= 4'h1 << n;
			@(posedge ref_clk_in) periph_irq_in <= 4'h0;
			xfer(0, 2);
		end
		// both channels see one pin edge together, rising then falling
		for (int s = 5; s < 7; s++) begin
			for (int c = 0; c < 2; c++) begin
				apb(1, 8'(c * 32), {20'h0, s[2:0], 9'h000});
				apb(1, 8'(c * 32 + 4), 0);
				apb(1, 8'(c * 32 + 16), 1);
				apb(1, 8'(c * 32), {20'h0, s[2:0], 9'h001});
			end
			@(posedge ref_clk_in) external_interrupt_input_in <= (s == 5) ? 2'h3 : 2'h0;
			xfer(0, 2);
			xfer(1, 2);
		end
		close_out();
	end
endmodule : dma_request_and_cycle_control_bench
`default_nettype wire
